//--- crf_map.vh
`ifndef CRF_MAP_VH
`define CRF_MAP_VH

// Core register select codes
`define CRF_SEL_D0      4'h0
`define CRF_SEL_D1      4'h1
`define CRF_SEL_D2      4'h2
`define CRF_SEL_D3      4'h3
`define CRF_SEL_AR0     4'h4
`define CRF_SEL_AR1     4'h5
`define CRF_SEL_FRM     4'h6
`define CRF_SEL_STB     4'h7
`define CRF_SEL_USTK    4'h8
`define CRF_SEL_ISTK    4'h9
`define CRF_SEL_SP      4'hA
`define CRF_SEL_VTB     4'hB
`define CRF_SEL_PC      4'hC
`define CRF_SEL_PSW     4'hD

// Access sizes
`define CRF_SZ_LO       2'h0
`define CRF_SZ_HI       2'h1
`define CRF_SZ_WORD     2'h2
`define CRF_SZ_LONG     2'h3

// Banked registers per bank, index of the last banked entry, pair step
`define CRF_BANK_REGS   4'h7
`define CRF_BANK_LAST   4'hD
`define CRF_PAIR_STEP   4'h2

// Status word bit positions
`define CRF_PSW_C       0
`define CRF_PSW_D       1
`define CRF_PSW_Z       2
`define CRF_PSW_S       3
`define CRF_PSW_B       4
`define CRF_PSW_O       5
`define CRF_PSW_I       6
`define CRF_PSW_U       7
`define CRF_PSW_RST     11'h000

// Flag update mask bits
`define CRF_FM_C        0
`define CRF_FM_Z        1
`define CRF_FM_S        2
`define CRF_FM_O        3

// APB word indices (byte address = index * 4)
`define CRF_IDX_BANK_END 5'h0D
`define CRF_IDX_VTB     5'h0E
`define CRF_IDX_PC      5'h0F
`define CRF_IDX_USTK    5'h10
`define CRF_IDX_ISTK    5'h11
`define CRF_IDX_STB     5'h12
`define CRF_IDX_PSW     5'h13
`define CRF_IDX_LSB     2
`define CRF_IDX_MSB     6

// Reset values
`define CRF_REG_RST     16'h0000
`define CRF_ADR_RST     20'h00000

`endif

//--- crf_cpu_regfile.v
// Function
// - Thirteen CPU registers; data, address, frame base form a bank.
// - Two full bank copies; bank flag 0 picks bank zero, 1 bank one.
// - Data registers are 16 bits; first two also split into bytes.
// - Third pairs with first, fourth with second; higher one is upper half.
// - Address registers 16 bits, usable as bases and general operands.
// - Both address registers join into one 32-bit value, second on top.
// - Frame base register is 16 bits and feeds frame-relative addressing.
// - Vector table base is 20 bits, holds the vector table start.
// - Program counter is 20 bits and points at the next instruction.
// - Separate user and interrupt stack pointers; stack flag picks one.
// - Static base register is 16 bits for static-relative addressing.
// - Status word is 11 bits with condition, debug, bank, stack flags.
// - Carry flag captures carry, borrow or shifted-out bit from ALU.
// - Zero flag is 1 for a zero result, otherwise 0.
// - Sign flag is 1 for a negative result, otherwise 0.
// - Overflow flag is 1 on overflow, otherwise 0.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`include "crf_map.vh"
`default_nettype none

module crf_cpu_regfile #(
    parameter ADDR_W = 12,
    parameter DW     = 16,
    parameter AW     = 20,
    parameter FW     = 11
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              ce,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    input  wire [3:0]        rd_a_sel,
    input  wire [1:0]        rd_a_size,
    output reg  [31:0]       rd_a_data,
    input  wire [3:0]        rd_b_sel,
    input  wire [1:0]        rd_b_size,
    output reg  [31:0]       rd_b_data,
    input  wire              wr_en,
    input  wire [3:0]        wr_sel,
    input  wire [1:0]        wr_size,
    input  wire [31:0]       wr_data,
    input  wire              sp_adj_en,
    input  wire [DW-1:0]     sp_adj_delta,
    input  wire              pc_load,
    input  wire [AW-1:0]     pc_target,
    input  wire              pc_step_en,
    input  wire [3:0]        pc_step,
    input  wire              flag_upd,
    input  wire [3:0]        flag_mask,
    input  wire [1:0]        alu_size,
    input  wire [31:0]       alu_result,
    input  wire              alu_carry,
    input  wire              alu_ovf,
    output reg  [AW-1:0]     next_instruction_pointer,
    output reg  [AW-1:0]     vector_table_base,
    output reg  [DW-1:0]     static_base_pointer,
    output reg  [FW-1:0]     cpu_status_word
);

    reg  [DW-1:0] bank_mem_r [0:13];
    reg  [DW-1:0] user_stack_pointer_r;
    reg  [DW-1:0] interrupt_stack_pointer_r;
    reg           apb_rdy_r;
    reg  [DW-1:0] sp_nxt;
    integer       i;

    wire          bank_sel  = cpu_status_word[`CRF_PSW_B];
    wire          stack_sel = cpu_status_word[`CRF_PSW_U];
    wire [4:0]    pidx      = paddr[`CRF_IDX_MSB:`CRF_IDX_LSB];
    wire          phit;
    wire          apb_done;
    wire          apb_wr;

    // Index of a banked register inside the two-bank store
    function [3:0] bidx;
        input       b;
        input [3:0] sel;
        begin
            bidx = b ? (sel + `CRF_BANK_REGS) : sel;
        end
    endfunction

    // Upper partner of a 32-bit pair
    function [3:0] hsel;
        input [3:0] sel;
        begin
            if (sel == `CRF_SEL_AR0)
                hsel = `CRF_SEL_AR1;
            else
                hsel = sel + `CRF_PAIR_STEP;
        end
    endfunction

    function is_pair;
        input [3:0] sel;
        begin
            is_pair = (sel == `CRF_SEL_D0) || (sel == `CRF_SEL_D1) ||
                      (sel == `CRF_SEL_AR0);
        end
    endfunction

    function is_byte_ok;
        input [3:0] sel;
        begin
            is_byte_ok = (sel == `CRF_SEL_D0) || (sel == `CRF_SEL_D1);
        end
    endfunction

    function is_banked;
        input [3:0] sel;
        begin
            is_banked = (sel <= `CRF_SEL_FRM);
        end
    endfunction

    // Word view of any core-selectable register in the current bank
    function [AW-1:0] rd_word;
        input [3:0] sel;
        begin
            if (is_banked(sel))
                rd_word = {4'h0, bank_mem_r[bidx(bank_sel, sel)]};
            else begin
                case (sel)
                    `CRF_SEL_STB:  rd_word = {4'h0, static_base_pointer};
                    `CRF_SEL_USTK: rd_word = {4'h0, user_stack_pointer_r};
                    `CRF_SEL_ISTK: rd_word = {4'h0, interrupt_stack_pointer_r};
                    `CRF_SEL_SP:   rd_word = {4'h0, sp_nxt};
                    `CRF_SEL_VTB:  rd_word = vector_table_base;
                    `CRF_SEL_PC:   rd_word = next_instruction_pointer;
                    `CRF_SEL_PSW:  rd_word = {9'h000, cpu_status_word};
                    default:       rd_word = `CRF_ADR_RST;
                endcase
            end
        end
    endfunction

    // Sized read: byte halves, word, or 32-bit pair
    function [31:0] rd_sized;
        input [3:0] sel;
        input [1:0] size;
        reg   [AW-1:0] w;
        reg   [AW-1:0] h;
        begin
            w = rd_word(sel);
            h = rd_word(hsel(sel));
            case (size)
                `CRF_SZ_LO:   rd_sized = {24'h000000, w[7:0]};
                `CRF_SZ_HI:   rd_sized = {24'h000000, w[15:8]};
                `CRF_SZ_WORD: rd_sized = {16'h0000, w[15:0]};
                `CRF_SZ_LONG: begin
                    if (is_pair(sel))
                        rd_sized = {h[15:0], w[15:0]};
                    else
                        rd_sized = {12'h000, w};
                end
                default:      rd_sized = 32'h00000000;
            endcase
        end
    endfunction

    function res_zero;
        input [1:0]  size;
        input [31:0] r;
        begin
            case (size)
                `CRF_SZ_LO,
                `CRF_SZ_HI:   res_zero = (r[7:0] == 8'h00);
                `CRF_SZ_WORD: res_zero = (r[15:0] == 16'h0000);
                default:      res_zero = (r == 32'h00000000);
            endcase
        end
    endfunction

    function res_neg;
        input [1:0]  size;
        input [31:0] r;
        begin
            case (size)
                `CRF_SZ_LO,
                `CRF_SZ_HI:   res_neg = r[7];
                `CRF_SZ_WORD: res_neg = r[15];
                default:      res_neg = r[31];
            endcase
        end
    endfunction

    function [31:0] apb_view;
        input [4:0] idx;
        begin
            if (idx <= `CRF_IDX_BANK_END)
                apb_view = {16'h0000, bank_mem_r[idx[3:0]]};
            else begin
                case (idx)
                    `CRF_IDX_VTB:  apb_view = {12'h000, vector_table_base};
                    `CRF_IDX_PC:   apb_view = {12'h000,
                                               next_instruction_pointer};
                    `CRF_IDX_USTK: apb_view = {16'h0000, user_stack_pointer_r};
                    `CRF_IDX_ISTK: apb_view = {16'h0000,
                                               interrupt_stack_pointer_r};
                    `CRF_IDX_STB:  apb_view = {16'h0000, static_base_pointer};
                    `CRF_IDX_PSW:  apb_view = {21'h000000, cpu_status_word};
                    default:       apb_view = 32'h00000000;
                endcase
            end
        end
    endfunction

    // Upper address bits must be clear so aliases never hit
    assign phit = (paddr[ADDR_W-1:`CRF_IDX_MSB+1] == {(ADDR_W-7){1'b0}}) &&
                  (pidx <= `CRF_IDX_PSW);

    // Ready waits one loaded cycle so a frozen setup phase still reads right
    assign pready   = psel & penable & apb_rdy_r & ce;
    assign apb_done = pready;
    assign apb_wr   = apb_done & pwrite & phit;
    assign pslverr  = pready & ~phit;

    always @* begin
        if (stack_sel)
            sp_nxt = user_stack_pointer_r;
        else
            sp_nxt = interrupt_stack_pointer_r;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata    <= 32'h00000000;
            apb_rdy_r <= 1'b0;
            rd_a_data <= 32'h00000000;
            rd_b_data <= 32'h00000000;
        end else if (ce) begin
            // Read functions see shared state, so they run only at the edge
            rd_a_data <= rd_sized(rd_a_sel, rd_a_size);
            rd_b_data <= rd_sized(rd_b_sel, rd_b_size);
            if (psel) begin
                if (penable && apb_rdy_r)
                    apb_rdy_r <= 1'b0;
                else begin
                    prdata    <= phit ? apb_view(pidx) : 32'h00000000;
                    apb_rdy_r <= 1'b1;
                end
            end else
                apb_rdy_r <= 1'b0;
        end
    end

    // Software writes first, core writes after: the core wins a clash
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i <= `CRF_BANK_LAST; i = i + 1)
                bank_mem_r[i] <= `CRF_REG_RST;
            user_stack_pointer_r      <= `CRF_REG_RST;
            interrupt_stack_pointer_r <= `CRF_REG_RST;
            static_base_pointer       <= `CRF_REG_RST;
            vector_table_base         <= `CRF_ADR_RST;
            next_instruction_pointer  <= `CRF_ADR_RST;
            cpu_status_word           <= `CRF_PSW_RST;
        end else if (ce) begin
            if (apb_wr) begin
                if (pidx <= `CRF_IDX_BANK_END)
                    bank_mem_r[pidx[3:0]] <= pwdata[DW-1:0];
                else begin
                    case (pidx)
                        `CRF_IDX_VTB:  vector_table_base <= pwdata[AW-1:0];
                        `CRF_IDX_PC:   next_instruction_pointer <=
                                           pwdata[AW-1:0];
                        `CRF_IDX_USTK: user_stack_pointer_r <= pwdata[DW-1:0];
                        `CRF_IDX_ISTK: interrupt_stack_pointer_r <=
                                           pwdata[DW-1:0];
                        `CRF_IDX_STB:  static_base_pointer <= pwdata[DW-1:0];
                        `CRF_IDX_PSW:  cpu_status_word <= pwdata[FW-1:0];
                        default: begin
                        end
                    endcase
                end
            end
            if (wr_en) begin
                if (is_banked(wr_sel)) begin
                    case (wr_size)
                        `CRF_SZ_LO: begin
                            if (is_byte_ok(wr_sel))
                                bank_mem_r[bidx(bank_sel, wr_sel)][7:0] <=
                                    wr_data[7:0];
                        end
                        `CRF_SZ_HI: begin
                            if (is_byte_ok(wr_sel))
                                bank_mem_r[bidx(bank_sel, wr_sel)][15:8] <=
                                    wr_data[7:0];
                        end
                        `CRF_SZ_LONG: begin
                            bank_mem_r[bidx(bank_sel, wr_sel)] <=
                                wr_data[15:0];
                            if (is_pair(wr_sel))
                                bank_mem_r[bidx(bank_sel, hsel(wr_sel))] <=
                                    wr_data[31:16];
                        end
                        default:
                            bank_mem_r[bidx(bank_sel, wr_sel)] <=
                                wr_data[DW-1:0];
                    endcase
                end else begin
                    case (wr_sel)
                        `CRF_SEL_STB:  static_base_pointer <=
                                           wr_data[DW-1:0];
                        `CRF_SEL_USTK: user_stack_pointer_r <=
                                           wr_data[DW-1:0];
                        `CRF_SEL_ISTK: interrupt_stack_pointer_r <=
                                           wr_data[DW-1:0];
                        `CRF_SEL_SP: begin
                            if (stack_sel)
                                user_stack_pointer_r <=
                                    wr_data[DW-1:0];
                            else
                                interrupt_stack_pointer_r <=
                                    wr_data[DW-1:0];
                        end
                        `CRF_SEL_VTB:  vector_table_base <=
                                           wr_data[AW-1:0];
                        `CRF_SEL_PC:   next_instruction_pointer <=
                                           wr_data[AW-1:0];
                        `CRF_SEL_PSW:  cpu_status_word <=
                                           wr_data[FW-1:0];
                        default: begin
                        end
                    endcase
                end
            end
            // Push and pop move only the active stack pointer
            if (sp_adj_en) begin
                if (stack_sel)
                    user_stack_pointer_r <= sp_nxt + sp_adj_delta;
                else
                    interrupt_stack_pointer_r <= sp_nxt + sp_adj_delta;
            end
            if (pc_load)
                next_instruction_pointer <= pc_target;
            else if (pc_step_en)
                next_instruction_pointer <= next_instruction_pointer +
                                            {16'h0000, pc_step};
            // ALU results beat any load of the status word in the same cycle
            if (flag_upd) begin
                if (flag_mask[`CRF_FM_C])
                    cpu_status_word[`CRF_PSW_C] <= alu_carry;
                if (flag_mask[`CRF_FM_Z])
                    cpu_status_word[`CRF_PSW_Z] <=
                        res_zero(alu_size, alu_result);
                if (flag_mask[`CRF_FM_S])
                    cpu_status_word[`CRF_PSW_S] <=
                        res_neg(alu_size, alu_result);
                if (flag_mask[`CRF_FM_O])
                    cpu_status_word[`CRF_PSW_O] <= alu_ovf;
            end
        end
    end

endmodule // crf_cpu_regfile

`default_nettype wire

//--- crf_cpu_regfile_props.sv
`default_nettype none
module crf_chk #(
    parameter DW = 16,
    parameter AW = 20,
    parameter FW = 11
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          ce,
    input wire logic          pc_load,
    input wire logic [AW-1:0] pc_target,
    input wire logic          pc_step_en,
    input wire logic [3:0]    pc_step,
    input wire logic          flag_upd,
    input wire logic [3:0]    flag_mask,
    input wire logic [1:0]    alu_size,
    input wire logic [31:0]   alu_result,
    input wire logic          alu_carry,
    input wire logic          alu_ovf,
    input wire logic [3:0]    rd_a_sel,
    input wire logic [1:0]    rd_a_size,
    input wire logic [31:0]   rd_a_data,
    input wire logic [AW-1:0] next_instruction_pointer,
    input wire logic [DW-1:0] static_base_pointer,
    input wire logic [FW-1:0] cpu_status_word
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // High-byte size left out: its flag width is not pinned down
    wire logic f = flag_upd && ce && alu_size != 2'h1;
    wire logic w16 = alu_size == 2'h2;
    wire logic w32 = alu_size == 2'h3;
    wire logic zr = w32 ? alu_result == 32'h0 :
        w16 ? alu_result[15:0] == 16'h0 : alu_result[7:0] == 8'h00;
    wire logic ng = w32 ? alu_result[31] :
        w16 ? alu_result[15] : alu_result[7];
    property p_carry;
        f && flag_mask[0] |=> cpu_status_word[0] == $past(alu_carry);
    endproperty
    a_carry: assert property (p_carry) else $error("carry flag");
    property p_zero;
        f && flag_mask[1] |=> cpu_status_word[2] == $past(zr);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    property p_sign;
        f && flag_mask[2] |=> cpu_status_word[3] == $past(ng);
    endproperty
    a_sign: assert property (p_sign) else $error("sign flag");
    property p_ovf;
        f && flag_mask[3] |=> cpu_status_word[5] == $past(alu_ovf);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag");
    property p_flrst;
        $rose(presetn) |-> cpu_status_word == 11'h000;
    endproperty
    a_flrst: assert property (p_flrst) else $error("flag reset");
    property p_freeze;
        !ce |=> $stable(cpu_status_word) && $stable(next_instruction_pointer);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved");
    property p_pcld;
        ce && pc_load |=> next_instruction_pointer == $past(pc_target);
    endproperty
    a_pcld: assert property (p_pcld) else $error("pc load");
    property p_pcst;
        ce && !pc_load && pc_step_en |=> next_instruction_pointer ==
            $past(next_instruction_pointer) + $past(pc_step);
    endproperty
    a_pcst: assert property (p_pcst) else $error("pc step");
    property p_sbrd;
        ce && rd_a_sel == 4'h7 && rd_a_size == 2'h2 |=>
            rd_a_data[DW-1:0] == $past(static_base_pointer);
    endproperty
    a_sbrd: assert property (p_sbrd) else $error("static base read");
endmodule // crf_chk
bind crf_cpu_regfile crf_chk #(.DW(DW), .AW(AW), .FW(FW)) u_chk (
    .pclk(pclk), .presetn(presetn), .ce(ce), .pc_load(pc_load),
    .pc_target(pc_target), .pc_step_en(pc_step_en), .pc_step(pc_step),
    .flag_upd(flag_upd), .flag_mask(flag_mask), .alu_size(alu_size),
    .alu_result(alu_result), .alu_carry(alu_carry), .alu_ovf(alu_ovf),
    .rd_a_sel(rd_a_sel), .rd_a_size(rd_a_size), .rd_a_data(rd_a_data),
    .next_instruction_pointer(next_instruction_pointer),
    .static_base_pointer(static_base_pointer),
    .cpu_status_word(cpu_status_word)
);
`default_nettype wire

//--- crf_core_model.sv
`default_nettype none
module crf_core_model (
    input  wire logic  pclk,
    output logic       wr_en,
    output logic [3:0] wr_sel,
    output logic [1:0] wr_size,
    output logic [31:0] wr_data,
    output logic       sp_adj_en,
    output logic [15:0] sp_adj_delta,
    output logic       pc_load,
    output logic [19:0] pc_target,
    output logic       pc_step_en,
    output logic [3:0] pc_step,
    output logic       flag_upd,
    output logic [3:0] flag_mask,
    output logic [1:0] alu_size,
    output logic [31:0] alu_result,
    output logic       alu_carry,
    output logic       alu_ovf
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {wr_en, sp_adj_en, pc_load, pc_step_en, flag_upd} = 5'h00;
        {wr_sel, wr_size, wr_data, sp_adj_delta} = 54'h0;
        {pc_target, pc_step, flag_mask, alu_size} = 30'h0;
        {alu_result, alu_carry, alu_ovf} = 34'h0;
    end
    // Released data is inverted so a stale value is never mistaken for live
    task automatic rel;
        @(posedge pclk);
        {wr_en, sp_adj_en, pc_load, pc_step_en, flag_upd} <= 5'h00;
        wr_data    <= ~wr_data;
        alu_result <= ~alu_result;
        alu_carry  <= ~alu_carry;
        #1;
    endtask
    task automatic wr(input logic [3:0] s, input logic [1:0] z,
                      input logic [31:0] d);
        @(posedge pclk);
        {wr_sel, wr_size, wr_en} <= {s, z, 1'b1};
        wr_data <= (s == 4'hD) ? (d & 32'hFFFFFFFD) : d;
        rel();
    endtask
    task automatic alu(input logic [3:0] m, input logic [1:0] z,
                       input logic [31:0] r, input logic c, input logic o);
        @(posedge pclk);
        {flag_mask, alu_size, alu_result} <= {m, z, r};
        {alu_carry, alu_ovf, flag_upd} <= {c, o, 1'b1};
        rel();
    endtask
    task automatic pc(input logic ld, input logic [19:0] t,
                      input logic [3:0] st);
        @(posedge pclk);
        {pc_load, pc_target, pc_step_en, pc_step} <= {ld, t, !ld, st};
        rel();
    endtask
    task automatic sp(input logic [15:0] d);
        @(posedge pclk);
        {sp_adj_en, sp_adj_delta} <= {1'b1, d};
        rel();
    endtask
endmodule // crf_core_model
`default_nettype wire

//--- crf_cpu_regfile_tb_top.sv
`default_nettype none
module crf_cpu_regfile_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] rd_a_sel = 4'h0, rd_b_sel = 4'h0;
    logic [1:0] rd_a_size = 2'h0, rd_b_size = 2'h0;
    wire logic pready, pslverr, wr_en, sp_adj_en, pc_load, pc_step_en;
    wire logic flag_upd, alu_carry, alu_ovf;
    wire logic [31:0] prdata, rd_a_data, rd_b_data, wr_data, alu_result;
    wire logic [3:0] wr_sel, pc_step, flag_mask;
    wire logic [1:0] wr_size, alu_size;
    wire logic [15:0] sp_adj_delta, static_base_pointer;
    wire logic [19:0] pc_target, next_instruction_pointer, vector_table_base;
    wire logic [10:0] cpu_status_word;
    int num_errors = 0, tests_run = 0;
    crf_cpu_regfile dut (.*);
    crf_core_model core (.*);
    always #5 pclk = ~pclk;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [31:0] e,
                       input logic er);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
        if (!w) chk("prdata", e, prdata);
        chk("pslverr", {31'h0, er}, {31'h0, pslverr});
        {psel, penable} <= 2'b00;
        #1;
    endtask
    task automatic crd(input logic [3:0] s, input logic [1:0] z,
                       input logic [31:0] e);
        @(posedge pclk);
        {rd_a_sel, rd_a_size, rd_b_sel, rd_b_size} <= {s, z, s, z};
        @(posedge pclk);
        #1;
        chk("rd_a_data", e, rd_a_data);
        chk("rd_b_data", e, rd_b_data);
    endtask
    task automatic t_reset;
        chk("flags", 32'h0, {21'h0, cpu_status_word});
        chk("pc", 32'h0, {12'h0, next_instruction_pointer});
        chk("vector base", 32'h0, {12'h0, vector_table_base});
        apb(1'b0, 12'h04C, 32'h0, 32'h0, 1'b0);
        $display("reset test done");
    endtask
    task automatic t_bank;
        core.wr(4'h0, 2'h2, 32'h1234);
        core.wr(4'h2, 2'h2, 32'h5678);
        crd(4'h0, 2'h3, 32'h56781234);
        core.wr(4'h0, 2'h1, 32'hAB);
        crd(4'h0, 2'h1, 32'hAB);
        crd(4'h0, 2'h0, 32'h34);
        core.wr(4'hD, 2'h2, 32'h10);
        core.wr(4'h0, 2'h2, 32'h9999);
        crd(4'h0, 2'h2, 32'h9999);
        apb(1'b0, 12'h000, 32'h0, 32'hAB34, 1'b0);
        apb(1'b0, 12'h01C, 32'h0, 32'h9999, 1'b0);
        core.wr(4'hD, 2'h2, 32'h0);
        crd(4'h0, 2'h2, 32'hAB34);
        core.wr(4'h1, 2'h3, 32'hCAFEBEEF);
        apb(1'b0, 12'h00C, 32'h0, 32'hCAFE, 1'b0);
        $display("bank test done");
    endtask
    task automatic t_addr;
        core.wr(4'h4, 2'h3, 32'h00C0FFEE);
        crd(4'h4, 2'h3, 32'h00C0FFEE);
        apb(1'b0, 12'h014, 32'h0, 32'h00C0, 1'b0);
        apb(1'b1, 12'h010, 32'h1111, 32'h0, 1'b0);
        crd(4'h4, 2'h2, 32'h1111);
        core.wr(4'h6, 2'h2, 32'h7777);
        apb(1'b0, 12'h018, 32'h0, 32'h7777, 1'b0);
        $display("address test done");
    endtask
    task automatic t_sp;
        apb(1'b1, 12'h040, 32'h2000, 32'h0, 1'b0);
        apb(1'b1, 12'h044, 32'h3000, 32'h0, 1'b0);
        crd(4'hA, 2'h2, 32'h3000);
        core.sp(16'h0010);
        apb(1'b0, 12'h044, 32'h0, 32'h3010, 1'b0);
        apb(1'b0, 12'h040, 32'h0, 32'h2000, 1'b0);
        core.wr(4'hD, 2'h2, 32'h80);
        crd(4'hA, 2'h2, 32'h2000);
        core.wr(4'hD, 2'h2, 32'h0);
        $display("stack test done");
    endtask
    task automatic t_flag;
        logic [1:0] z[4] = '{2'h2, 2'h0, 2'h3, 2'h2};
        logic [31:0] r[4] = '{32'h0, 32'h180, 32'h80000000, 32'h10000};
        logic [10:0] e[4] = '{11'h005, 11'h028, 11'h008, 11'h004};
        logic [3:0] c = 4'b0001;
        logic [3:0] o = 4'b0010;
        for (int i = 0; i < 4; i++) begin
            core.alu(4'hF, z[i], r[i], c[i], o[i]);
            chk("flags", {21'h0, e[i]}, {21'h0, cpu_status_word});
        end
        core.alu(4'h1, 2'h2, 32'h1, 1'b1, 1'b0);
        chk("flags", 32'h005, {21'h0, cpu_status_word});
        @(posedge pclk);
        ce <= 1'b0;
        core.alu(4'hF, 2'h2, 32'h8000, 1'b0, 1'b1);
        chk("flags", 32'h005, {21'h0, cpu_status_word});
        @(posedge pclk);
        ce <= 1'b1;
        core.wr(4'hD, 2'h2, 32'h0);
        $display("flag test done");
    endtask
    task automatic t_pc;
        apb(1'b1, 12'h038, 32'hFFFFFFFF, 32'h0, 1'b0);
        chk("vector base", 32'hFFFFF, {12'h0, vector_table_base});
        apb(1'b1, 12'h048, 32'h0001ABCD, 32'h0, 1'b0);
        chk("static base", 32'hABCD, {16'h0, static_base_pointer});
        crd(4'h7, 2'h2, 32'hABCD);
        core.pc(1'b1, 20'hF0000, 4'h0);
        core.pc(1'b0, 20'h0, 4'h3);
        crd(4'hC, 2'h3, 32'h000F0003);
        apb(1'b0, 12'h050, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h080, 32'h5, 32'h0, 1'b1);
        apb(1'b0, 12'h000, 32'h0, 32'hAB34, 1'b0);
        $display("pc test done");
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        t_reset();
        t_bank();
        t_addr();
        t_sp();
        t_flag();
        t_pc();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        t_reset();
        report_and_stop();
    end
endmodule // crf_cpu_regfile_tb_top
`default_nettype wire
